// ### logic/ccsg_top.v
// cluster control signal generator with its sixteen cell registers and register bus
// Function
// - the controller offers three clock lines, three gates, two async clears, one sync clear, one async load and one sync load, at most 11 active.
// - no more than two distinct source clocks may be in use across the three lines.
// - each clock line has its own gate and a register on a line always uses that line's gate.
// - using both edges of one source takes two clock lines.
// - a low gate stops its clock line so no register on it is clocked; gate zero is held open while the async load/preset is in use.
// - two independent async clears and one async load/preset reach the cell registers.
// - with load data high the async load sets the register to one as a preset.
// - while the async load/preset is in use gate zero is unavailable.
// - controls come from the six row clocks [5..0] and from local routing.
// - a chain path carries one cell register's output into the adjacent register.
// - eight logic cells share the controller for their register controls.
// - all cluster-wide controls reach the registers in every cell mode.
// - async load data comes from one of the cell's two upper data inputs.
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "ccsg_regs.vh"
module ccsg_top
(
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // avalon-mm slave
  input wire [`CCSG_ADDR_W-1:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // clock sources
  input wire [`CCSG_ROW_CLOCKS-1:0] i_row_clock,
  input wire [`CCSG_CLOCK_LINES-1:0] i_local_clock,
  // local routing controls
  input wire [`CCSG_CLOCK_LINES-1:0] i_cluster_clock_gate,
  input wire i_cluster_async_clear_0,
  input wire i_cluster_async_clear_1,
  input wire i_cluster_preset,
  input wire i_sync_clear,
  input wire i_sync_load,
  // cell data, two registers per logic cell
  input wire [`CCSG_CELL_REGS-1:0] i_cell_data,
  input wire [`CCSG_CELL_REGS-1:0] i_cell_datae,
  input wire [`CCSG_CELL_REGS-1:0] i_cell_dataf,
  // cell and line outputs
  output wire [`CCSG_CELL_REGS-1:0] o_cell_q,
  output wire [`CCSG_CLOCK_LINES-1:0] o_cluster_clock_line,
  output reg o_config_error_q
);

  localparam NL = `CCSG_CLOCK_LINES;
  localparam NR = `CCSG_CELL_REGS;

  reg [31:0] line_sel_q;
  reg [31:0] ctrl_q;
  reg [31:0] cell_line_q;
  reg [31:0] cell_opt_q;
  reg [31:0] chain_q;
  reg ack_q;

  wire [2:0] src0;
  wire [2:0] src1;
  wire [2:0] src2;
  wire [NL-1:0] line_en_cfg;
  wire [NL-1:0] line_en;
  wire [NL-1:0] line_source;
  wire [NL-1:0] line_fall;
  wire [NL-1:0] gate_eff;
  wire [NL-1:0] tick;
  wire three_sources;
  wire aload_use;
  wire aclr0;
  wire aclr1;
  wire aload;
  wire sclr;
  wire sload;
  wire [1:0] lines_on;
  wire [1:0] gates_on;
  wire [1:0] clears_on;
  wire [1:0] syncs_on;
  wire [3:0] active_count;
  wire req;
  wire [31:0] status_word;
  reg [31:0] rd_d;

  // avalon handshake: one wait cycle, then a single ready cycle
  assign req = i_avs_read | i_avs_write;

  function [31:0] merge_be;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer b;
    begin
      merge_be = old_v;
      for (b = 0; b < 4; b = b + 1)
        if (be[b])
          merge_be[b*8 +: 8] = new_v[b*8 +: 8];
    end
  endfunction

  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ack_q <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      // kept as its own flop so the pin is the inverse of the ack state without a gate behind it
      o_avs_waitrequest <= ~(req & ~ack_q);
      if (req & ~ack_q)
        o_avs_readdata <= i_avs_read ? rd_d : 32'h0000_0000;
    end
  end

  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      line_sel_q <= `CCSG_RST_LINE_SEL;
      ctrl_q <= `CCSG_RST_CTRL;
      cell_line_q <= `CCSG_RST_CELL_LINE;
      cell_opt_q <= `CCSG_RST_CELL_OPT;
      chain_q <= `CCSG_RST_CHAIN;
    end
    else if (i_avs_write & ack_q)
    begin
      case (i_avs_address)
        `CCSG_OFS_LINE_SEL: line_sel_q <= merge_be(line_sel_q, i_avs_writedata, i_avs_byteenable);
        `CCSG_OFS_CTRL: ctrl_q <= merge_be(ctrl_q, i_avs_writedata, i_avs_byteenable);
        `CCSG_OFS_CELL_LINE: cell_line_q <= merge_be(cell_line_q, i_avs_writedata, i_avs_byteenable);
        `CCSG_OFS_CELL_OPT: cell_opt_q <= merge_be(cell_opt_q, i_avs_writedata, i_avs_byteenable);
        `CCSG_OFS_CHAIN: chain_q <= merge_be(chain_q, i_avs_writedata, i_avs_byteenable);
        default: ;
      endcase
    end
  end

  always @*
  begin
    case (i_avs_address)
      `CCSG_OFS_LINE_SEL: rd_d = line_sel_q;
      `CCSG_OFS_CTRL: rd_d = ctrl_q;
      `CCSG_OFS_CELL_LINE: rd_d = cell_line_q;
      `CCSG_OFS_CELL_OPT: rd_d = cell_opt_q;
      `CCSG_OFS_CHAIN: rd_d = {16'h0000, chain_q[15:0]};
      `CCSG_OFS_STATUS: rd_d = status_word;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // per-line source selection
  assign src0 = line_sel_q[`CCSG_LINE_SRC_LSB +: 3];
  assign src1 = line_sel_q[`CCSG_LINE_FIELD_W + `CCSG_LINE_SRC_LSB +: 3];
  assign src2 = line_sel_q[2*`CCSG_LINE_FIELD_W + `CCSG_LINE_SRC_LSB +: 3];
  assign line_en_cfg = ctrl_q[`CCSG_CTRL_LINE_EN_LSB +: NL];

  // same source on two lines counts once, so rising plus falling fits the limit
  assign three_sources = &line_en_cfg & (src0 != src1) & (src0 != src2) & (src1 != src2);
  // a third distinct source is refused by holding line 2 off
  assign line_en = {line_en_cfg[2] & ~three_sources, line_en_cfg[1:0]};

  function pick_source;
    input [2:0] sel;
    input [`CCSG_ROW_CLOCKS-1:0] rows;
    input local_clk;
    begin
      if (sel == `CCSG_SRC_LOCAL)
        pick_source = local_clk;
      else if (sel < 3'h6)
        pick_source = rows[sel];
      else
        pick_source = 1'b0;
    end
  endfunction

  assign line_source[0] = pick_source(src0, i_row_clock, i_local_clock[0]);
  assign line_source[1] = pick_source(src1, i_row_clock, i_local_clock[1]);
  assign line_source[2] = pick_source(src2, i_row_clock, i_local_clock[2]);

  assign line_fall[0] = line_sel_q[`CCSG_LINE_FALL_BIT];
  assign line_fall[1] = line_sel_q[`CCSG_LINE_FIELD_W + `CCSG_LINE_FALL_BIT];
  assign line_fall[2] = line_sel_q[2*`CCSG_LINE_FIELD_W + `CCSG_LINE_FALL_BIT];

  assign aload_use = ctrl_q[`CCSG_CTRL_ALOAD_BIT];
  // gate 0 shares its routing with the preset, so it is forced open then
  assign gate_eff = {i_cluster_clock_gate[2:1], i_cluster_clock_gate[0] | aload_use};

  genvar gl;
  generate
    for (gl = 0; gl < NL; gl = gl + 1)
    begin : g_line
      ccsg_clock_line u_line
      (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_source(line_source[gl]),
        .i_falling(line_fall[gl]),
        .i_line_enable(line_en[gl]),
        .i_gate(gate_eff[gl]),
        .o_tick_q(tick[gl])
      );
    end
  endgenerate

  assign o_cluster_clock_line = tick;

  // controls only act when enabled in the control register
  assign aclr0 = i_cluster_async_clear_0 & ctrl_q[`CCSG_CTRL_ACLR0_BIT];
  assign aclr1 = i_cluster_async_clear_1 & ctrl_q[`CCSG_CTRL_ACLR1_BIT];
  assign aload = i_cluster_preset & aload_use;
  assign sclr = i_sync_clear & ctrl_q[`CCSG_CTRL_SCLR_BIT];
  assign sload = i_sync_load & ctrl_q[`CCSG_CTRL_SLOAD_BIT];

  // lines, usable gates, two clears, preset, sync clear, sync load
  assign lines_on = {1'b0, line_en[0]} + {1'b0, line_en[1]} + {1'b0, line_en[2]};
  // gate zero drops out of the count while its routing carries the preset
  assign gates_on = 2'h2 + {1'b0, ~aload_use};
  assign clears_on = {1'b0, ctrl_q[`CCSG_CTRL_ACLR0_BIT]} + {1'b0, ctrl_q[`CCSG_CTRL_ACLR1_BIT]};
  assign syncs_on = {1'b0, ctrl_q[`CCSG_CTRL_SCLR_BIT]} + {1'b0, ctrl_q[`CCSG_CTRL_SLOAD_BIT]};
  assign active_count = {2'b00, lines_on} + {2'b00, gates_on} + {2'b00, clears_on} + {2'b00, syncs_on}
    + {3'b000, aload_use};

  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_config_error_q <= 1'b0;
    else
      o_config_error_q <= three_sources | (active_count > `CCSG_MAX_CONTROLS);
  end

  assign status_word = {4'h0, active_count, 4'h0, o_config_error_q, tick, o_cell_q};

  // each of the eight cells holds two registers, all fed from the shared controls
  genvar gr;
  generate
    for (gr = 0; gr < NR; gr = gr + 1)
    begin : g_cell
      wire [1:0] lsel;
      wire reg_tick;
      wire reg_aclr;
      wire reg_aldata;
      wire reg_d;
      assign lsel = cell_line_q[2*gr +: 2];
      // the line choice brings its own gate with it through the tick
      assign reg_tick = (lsel == 2'h0) ? tick[0] : (lsel == 2'h1) ? tick[1] : (lsel == 2'h2) ? tick[2] : 1'b0;
      assign reg_aclr = cell_opt_q[`CCSG_OPT_CLRSEL_LSB + gr] ? aclr1 : aclr0;
      assign reg_aldata = cell_opt_q[`CCSG_OPT_ALDSEL_LSB + gr] ? i_cell_dataf[gr] : i_cell_datae[gr];
      if (gr == 0)
      begin : g_head
        assign reg_d = i_cell_data[gr];
      end
      else
      begin : g_link
        assign reg_d = chain_q[gr] ? o_cell_q[gr-1] : i_cell_data[gr];
      end
      ccsg_cell_reg u_reg
      (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_tick(reg_tick),
        .i_async_clear(reg_aclr),
        .i_async_load(aload),
        .i_sync_clear(sclr),
        .i_sync_load(sload),
        .i_data(reg_d),
        .i_async_load_data(reg_aldata),
        .o_q(o_cell_q[gr])
      );
    end
  endgenerate

endmodule // ccsg_top

// ### logic/ccsg_regs.vh
// register map, field positions, reset values and counts for the cluster control generator
`ifndef CCSG_REGS_VH
`define CCSG_REGS_VH

`define CCSG_ADDR_W 5
`define CCSG_OFS_LINE_SEL 5'h00
`define CCSG_OFS_CTRL 5'h04
`define CCSG_OFS_CELL_LINE 5'h08
`define CCSG_OFS_CELL_OPT 5'h0C
`define CCSG_OFS_CHAIN 5'h10
`define CCSG_OFS_STATUS 5'h14

`define CCSG_ROW_CLOCKS 6
`define CCSG_CLOCK_LINES 3
`define CCSG_CELLS 8
`define CCSG_CELL_REGS 16
`define CCSG_MAX_CONTROLS 4'hB
`define CCSG_SRC_LOCAL 3'h6

`define CCSG_LINE_FIELD_W 4
`define CCSG_LINE_SRC_LSB 0
`define CCSG_LINE_FALL_BIT 3

`define CCSG_CTRL_LINE_EN_LSB 0
`define CCSG_CTRL_ALOAD_BIT 3
`define CCSG_CTRL_ACLR0_BIT 4
`define CCSG_CTRL_ACLR1_BIT 5
`define CCSG_CTRL_SCLR_BIT 6
`define CCSG_CTRL_SLOAD_BIT 7

`define CCSG_OPT_CLRSEL_LSB 0
`define CCSG_OPT_ALDSEL_LSB 16

`define CCSG_STAT_Q_LSB 0
`define CCSG_STAT_TICK_LSB 16
`define CCSG_STAT_ERR_BIT 19
`define CCSG_STAT_CNT_LSB 24

`define CCSG_RST_LINE_SEL 32'h0000_0000
`define CCSG_RST_CTRL 32'h0000_0000
`define CCSG_RST_CELL_LINE 32'h0000_0000
`define CCSG_RST_CELL_OPT 32'h0000_0000
`define CCSG_RST_CHAIN 32'h0000_0000

`endif

// ### logic/ccsg_clock_line.v
// one cluster clock line: edge pick on the chosen source, gated by its linked enable
`timescale 1ns/10ps
module ccsg_clock_line
(
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // source and control
  input wire i_source,
  input wire i_falling,
  input wire i_line_enable,
  input wire i_gate,
  // line activity
  output reg o_tick_q
);

  reg level_q;
  wire edge_seen;

  assign edge_seen = i_falling ? (level_q & ~i_source) : (~level_q & i_source);

  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      level_q <= 1'b0;
      o_tick_q <= 1'b0;
    end
    else
    begin
      level_q <= i_source;
      // a low gate stops the line altogether
      o_tick_q <= i_line_enable & i_gate & edge_seen;
    end
  end

endmodule // ccsg_clock_line

// ### logic/ccsg_cell_reg.v
// one logic cell register driven by the shared cluster controls
`timescale 1ns/10ps
module ccsg_cell_reg
(
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // cluster-wide controls
  input wire i_tick,
  input wire i_async_clear,
  input wire i_async_load,
  input wire i_sync_clear,
  input wire i_sync_load,
  // data
  input wire i_data,
  input wire i_async_load_data,
  // register output
  output reg o_q
);

  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_q <= 1'b0;
    else if (i_async_clear)
      o_q <= 1'b0;
    else if (i_async_load)
      // tied-high load data turns this into a preset
      o_q <= i_async_load_data;
    else if (i_tick)
    begin
      if (i_sync_clear)
        o_q <= 1'b0;
      else if (i_sync_load)
        o_q <= i_async_load_data;
      else
        o_q <= i_data;
    end
  end

endmodule // ccsg_cell_reg

// ### verif/ccsg_row_source.sv
// row and local clock sources feeding the cluster
`timescale 1ns/10ps
module ccsg_row_source
(
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // control
  input wire i_run,
  // clock sources
  output wire [5:0] o_row_clock,
  output wire [2:0] o_local_clock
);
  reg [6:0] cnt_q;
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_q <= 7'h00;
    else if (i_run)
      cnt_q <= cnt_q + 7'h01;
  end
  // each row runs at half the rate of the one below, so no two rows ever rise in the same cycle
  assign o_row_clock = cnt_q[6:1];
  assign o_local_clock = cnt_q[3:1];
endmodule // ccsg_row_source

// ### verif/ccsg_top_assertions.sv
// port-level checker for the cluster control generator
`timescale 1ns/10ps
`include "ccsg_regs.vh"
module ccsg_checker
(
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // bus
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  // cluster
  input wire [`CCSG_CLOCK_LINES-1:0] i_cluster_clock_gate,
  input wire [`CCSG_CELL_REGS-1:0] o_cell_q,
  input wire [`CCSG_CLOCK_LINES-1:0] o_cluster_clock_line,
  input wire o_config_error_q
);
  reg cfg_q;
  wire req = i_avs_read || i_avs_write;
  // nothing is configured before the first accepted write
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cfg_q <= 1'b0;
    else if (i_avs_write && !o_avs_waitrequest)
      cfg_q <= 1'b1;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_pending;
    req && o_avs_waitrequest;
  endsequence
  sequence s_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  a_wait_one: assert property (s_pending |=> s_answer) else $error("bus answer not one cycle");
  a_wait_idle: assert property (!req |=> o_avs_waitrequest) else $error("answer without request");
  a_rdata_hold: assert property (!req |=> $stable(o_avs_readdata)) else $error("read data moved");
  a_gate_one: assert property ((!i_cluster_clock_gate[1]) [*2] |=> !o_cluster_clock_line[1]) else $error("line 1 ran");
  a_gate_two: assert property ((!i_cluster_clock_gate[2]) [*2] |=> !o_cluster_clock_line[2]) else $error("line 2 ran");
  a_pulse_single: assert property (o_cluster_clock_line[0] |=> !o_cluster_clock_line[0]) else $error("long pulse");
  a_error_line: assert property (o_config_error_q && $past(o_config_error_q) |-> !o_cluster_clock_line[2])
    else $error("line 2 ran with three sources");
  a_idle_cfg: assert property (!cfg_q |-> o_cluster_clock_line == 3'h0 && o_cell_q == 16'h0000)
    else $error("activity before configuration");
endmodule // ccsg_checker
bind ccsg_top ccsg_checker u_checker (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_cluster_clock_gate(i_cluster_clock_gate), .o_cell_q(o_cell_q), .o_cluster_clock_line(o_cluster_clock_line),
  .o_config_error_q(o_config_error_q));

// ### verif/cluster_control_signal_gen_tb_top.sv
// register-driven tests of the cluster control generator
`timescale 1ns/10ps
module cluster_control_signal_gen_tb_top;
  reg i_clock, i_rst_n, i_avs_read, i_avs_write;
  reg [4:0] i_avs_address;
  reg [31:0] i_avs_writedata, r;
  reg [2:0] i_cluster_clock_gate;
  reg i_cluster_async_clear_0, i_cluster_async_clear_1, i_cluster_preset, i_sync_clear, i_sync_load;
  reg [15:0] i_cell_data, i_cell_datae, i_cell_dataf;
  wire [31:0] o_avs_readdata;
  wire o_avs_waitrequest, o_config_error_q;
  wire [5:0] i_row_clock;
  wire [2:0] i_local_clock, o_cluster_clock_line;
  wire [15:0] o_cell_q;
  integer failures, samples_checked, i;
  ccsg_top u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_row_clock(i_row_clock),
    .i_local_clock(i_local_clock), .i_cluster_clock_gate(i_cluster_clock_gate),
    .i_cluster_async_clear_0(i_cluster_async_clear_0), .i_cluster_async_clear_1(i_cluster_async_clear_1),
    .i_cluster_preset(i_cluster_preset), .i_sync_clear(i_sync_clear), .i_sync_load(i_sync_load),
    .i_cell_data(i_cell_data), .i_cell_datae(i_cell_datae), .i_cell_dataf(i_cell_dataf), .o_cell_q(o_cell_q),
    .o_cluster_clock_line(o_cluster_clock_line), .o_config_error_q(o_config_error_q));
  ccsg_row_source u_src (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_run(1'b1), .o_row_clock(i_row_clock),
    .o_local_clock(i_local_clock));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // holds the request until waitrequest is seen low at an edge; only the watchdog ends a hang
  task bus(input rd, input [4:0] a, input [31:0] d, output [31:0] q);
    begin
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_read <= rd;
      i_avs_write <= !rd;
      @(posedge i_clock);
      while (o_avs_waitrequest !== 1'b0)
        @(posedge i_clock);
      q = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      @(posedge i_clock);
    end
  endtask
  // counts line pulses, then lets the registers on that line update
  task edges(input integer k, input integer n);
    integer c, t;
    begin
      c = 0;
      t = 0;
      while (c < n && t < 500)
      begin
        @(posedge i_clock);
        t = t + 1;
        if (o_cluster_clock_line[k] === 1'b1)
          c = c + 1;
      end
      chk(c, n);
      repeat (2) @(posedge i_clock);
    end
  endtask
  task complete_run;
    begin
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // the tests need about 450 cycles
  initial
  begin
    #1000000;
    failures = failures + 1;
    complete_run;
  end
  initial
  begin
    failures = 0;
    samples_checked = 0;
    {i_avs_read, i_avs_write, i_cluster_async_clear_0, i_cluster_async_clear_1} = 4'h0;
    {i_cluster_preset, i_sync_clear, i_sync_load, i_rst_n} = 4'h0;
    i_avs_address = 5'h00;
    i_avs_writedata = 32'h0000_0000;
    i_cluster_clock_gate = 3'h7;
    {i_cell_data, i_cell_datae, i_cell_dataf} = 48'h0;
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    bus(1'b0, 5'h18, 32'hFFFF_FFFF, r);
    for (i = 0; i < 6; i = i + 1)
    begin
      bus(1'b1, (i == 5) ? 5'h18 : {i[2:0], 2'b00}, 32'h0, r);
      chk(r, 32'h0000_0000);
    end
    $display("test reset done");
    bus(1'b0, 5'h00, 32'h0000_0010, r);
    bus(1'b0, 5'h04, 32'h0000_0002, r);
    bus(1'b0, 5'h08, 32'h5555_5555, r);
    i_cell_data <= 16'hA5C3;
    edges(1, 2);
    chk({16'h0, o_cell_q}, 32'h0000_A5C3);
    i_cluster_clock_gate <= 3'h5;
    repeat (3) @(posedge i_clock);
    i_cell_data <= 16'h0F0F;
    repeat (40) @(posedge i_clock);
    chk({16'h0, o_cell_q}, 32'h0000_A5C3);
    i_cluster_clock_gate <= 3'h7;
    edges(1, 2);
    chk({16'h0, o_cell_q}, 32'h0000_0F0F);
    $display("test clock line done");
    i_cell_data <= 16'h0001;
    bus(1'b0, 5'h10, 32'h0000_FFFE, r);
    edges(1, 17);
    chk({16'h0, o_cell_q}, 32'h0000_FFFF);
    $display("test chain done");
    i_cluster_clock_gate <= 3'h5;
    bus(1'b0, 5'h0C, 32'h0000_AAAA, r);
    bus(1'b0, 5'h04, 32'h0000_0032, r);
    i_cluster_async_clear_0 <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk({16'h0, o_cell_q}, 32'h0000_AAAA);
    i_cluster_async_clear_1 <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk({16'h0, o_cell_q}, 32'h0000_0000);
    {i_cluster_async_clear_0, i_cluster_async_clear_1} <= 2'h0;
    $display("test clears done");
    bus(1'b0, 5'h0C, 32'h0000_0000, r);
    bus(1'b0, 5'h04, 32'h0000_000B, r);
    i_cluster_clock_gate <= 3'h4;
    i_cell_datae <= 16'hFFFF;
    i_cluster_preset <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk({16'h0, o_cell_q}, 32'h0000_FFFF);
    edges(0, 2);
    i_cluster_preset <= 1'b0;
    bus(1'b0, 5'h0C, 32'hFFFF_0000, r);
    i_cell_datae <= 16'h0000;
    i_cell_dataf <= 16'h3C3C;
    i_cluster_preset <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk({16'h0, o_cell_q}, 32'h0000_3C3C);
    i_cluster_preset <= 1'b0;
    $display("test preset done");
    bus(1'b0, 5'h10, 32'h0000_0000, r);
    bus(1'b0, 5'h04, 32'h0000_00C2, r);
    i_cell_dataf <= 16'h00FF;
    {i_sync_clear, i_sync_load} <= 2'h3;
    repeat (40) @(posedge i_clock);
    chk({16'h0, o_cell_q}, 32'h0000_3C3C);
    i_cluster_clock_gate <= 3'h7;
    edges(1, 2);
    chk({16'h0, o_cell_q}, 32'h0000_0000);
    i_sync_clear <= 1'b0;
    edges(1, 2);
    chk({16'h0, o_cell_q}, 32'h0000_00FF);
    i_sync_load <= 1'b0;
    $display("test sync controls done");
    bus(1'b0, 5'h04, 32'h0000_0007, r);
    for (i = 0; i < 3; i = i + 1)
    begin
      bus(1'b0, 5'h00, (i == 0) ? 32'h719 : ((i == 1) ? 32'h209 : 32'h119), r);
      bus(1'b1, 5'h14, 32'h0, r);
      chk({31'h0, r[19]}, (i == 1) ? 32'h1 : 32'h0);
      chk({28'h0, r[27:24]}, (i == 1) ? 32'h5 : 32'h6);
      chk({31'h0, o_config_error_q}, (i == 1) ? 32'h1 : 32'h0);
    end
    edges(0, 2);
    edges(1, 2);
    $display("test sources done");
    complete_run;
  end
endmodule // cluster_control_signal_gen_tb_top
